/* include/io_channel_consts.svh */
// Register offsets, field positions and reset values for the io channel bank
`ifndef IO_CHANNEL_CONSTS_SVH
`define IO_CHANNEL_CONSTS_SVH

`define CH_ADDR_W             4
`define CH_DATA_W             15
`define CH_NUM_OUT            3
`define CH_NUM_IN             6
`define CH_NUM_PINS           90

`define SUBSYS_CTRL_IDX       4'h0
`define RADAR_CTRL_IDX        4'h1
`define COUNTER_CTRL_IDX      4'h2
`define KEY_CODE_IDX          4'h3
`define MARK_RATE_IDX         4'h4
`define INERTIAL_STAT_IDX     4'h5
`define HAND_CTRL_IDX         4'h6
`define THRUSTER_FAIL_IDX     4'h7
`define RADAR_STAT_IDX        4'h8

`define OUT_RESET_VAL         15'h0000

`define KEY_CODE_MASK         15'h001F
`define MARK_RATE_MASK        15'h007C
`define INERTIAL_STAT_MASK    15'h7F7F
`define HAND_CTRL_MASK        15'h7FFF
`define THRUSTER_FAIL_MASK    15'h23FF
`define RADAR_STAT_MASK       15'h01FE

`endif

/* include/io_channel_pkg.sv */
// Types shared by the io channel bank
package io_channel_pkg;

  typedef logic [14:0] chan_word_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WRITE,
    ACC_READ
  } acc_kind_t;

endpackage

/* include/chan_store_if.sv */
// Carrier between the channel bank and its output word store
`timescale 1ns/10ps

interface chan_store_if;
  logic                     wr_en;
  logic [1:0]               wr_sel;
  io_channel_pkg::chan_word_t wr_data;
  io_channel_pkg::chan_word_t out_word [3];

  modport bank  (output wr_en, output wr_sel, output wr_data, input out_word);
  modport store (input wr_en, input wr_sel, input wr_data, output out_word);
endinterface

/* core/out_channel_store.sv */
// Holding registers for the three output channel words
`timescale 1ns/10ps
`include "io_channel_consts.svh"

module out_channel_store
(
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  chan_store_if.store st
);

  typedef struct packed {
    io_channel_pkg::chan_word_t [2:0] word;
  } store_state_t;

  store_state_t state_reg;
  store_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (st.wr_en && (st.wr_sel < 2'h3))
    begin
      state_next.word[st.wr_sel] = st.wr_data;  // [R25]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign st.out_word[0] = state_reg.word[0];
  assign st.out_word[1] = state_reg.word[1];
  assign st.out_word[2] = state_reg.word[2];

endmodule // out_channel_store

/* core/io_channel_bank.sv */
// Discrete output and input channel bank of the guidance computer
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "io_channel_consts.svh"

// Functional notes
// [R1] Subsystem control bits 9..12 drive descent engine pitch and roll trim.
// [R2] Subsystem control bit 8 enables the inertial data display path.
// [R3] Subsystem control bit 13 commands landing radar antenna repositioning.
// [R4] Subsystem control bit 14 enables rendezvous radar auto tracking.
// [R5] Subsystem control bit 15 signals inertial unit turn-on delay complete.
// [R6] Radar control bits 1..4 select radar data source and readout.
// [R7] Radar control bits 5..7 uplink/downlink, bits 8..9 hand controller.
// [R8] Radar control bit 10 suppresses restart alarm for caution tests.
// [R9] Radar control bit 11 set enables standby circuits.
// [R10] Radar control bits 12..14 reset rotation, translation, thruster-fail interrupts.
// [R11] Radar control bit 15 enables jet timing counter decrement.
// [R12] Counter control bit 1 enables crosslink serial word logic.
// [R13] Counter control bits 2..3 control altitude and rate indicator logic.
// [R14] Counter control bit 4 enables descent throttle gating logic.
// [R15] Counter control bits 6..10 control gyro torquing during fine alignment.
// [R16] Bits 11..12 drive radar antenna; bits 13..15 drive inertial gimbals.
// [R17] Keyboard presents five-bit key code on key code bits 1..5.
// [R18] Mark inputs bits 3..5 buttons; bits 6..7 descent rate switch.
// [R19] Inertial status bits 1..11 report switches, converter, power, cage; bit 8 spare.
// [R20] Inertial status bits 12..13 fail flags, 14 delay request, 15 temperature.
// [R21] Hand controller bits 1..6 impulse, 7..12 translation, 13..15 mode.
// [R22] Thruster bits 1..8 failed pairs, 9..10 gimbal, 11..13 spare, 14 proceed.
// [R23] Radar status bit 1 spare, 2..4 rendezvous, 5..9 landing radar.
// [R24] Each channel holds fifteen bits; outputs written, inputs read by software.
// [R25] Output bits hold their written value until the channel is rewritten.
module io_channel_bank
(
  input  wire logic [3:0]   addr_i,
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [14:0]  wr_data_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [14:0]  rd_data_o,
  input  wire logic [14:0]  key_code_pins_i,
  input  wire logic [14:0]  mark_rate_pins_i,
  input  wire logic [14:0]  inertial_stat_pins_i,
  input  wire logic [14:0]  hand_ctrl_pins_i,
  input  wire logic [14:0]  thruster_fail_pins_i,
  input  wire logic [14:0]  radar_stat_pins_i,
  output logic      [3:0]   descent_trim_o,
  output logic              display_inertial_en_o,
  output logic              landing_radar_position_o,
  output logic              rendezvous_radar_autotrack_o,
  output logic              turn_on_delay_done_o,
  output logic      [4:0]   subsystem_misc_o,
  output logic      [3:0]   radar_data_select_o,
  output logic      [2:0]   link_process_ctrl_o,
  output logic      [1:0]   hand_ctrl_process_o,
  output logic              restart_alarm_inhibit_o,
  output logic              standby_enable_o,
  output logic      [2:0]   interrupt_circuit_reset_o,
  output logic              jet_timing_counter_en_o,
  output logic              crosslink_enable_o,
  output logic      [1:0]   altitude_indicator_ctrl_o,
  output logic              throttle_gating_en_o,
  output logic              counter_spare_o,
  output logic      [4:0]   gyro_torque_ctrl_o,
  output logic      [1:0]   rendezvous_radar_drive_o,
  output logic      [2:0]   inertial_gimbal_drive_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    io_channel_pkg::chan_word_t [5:0] sync1;
    io_channel_pkg::chan_word_t [5:0] sync2;
    io_channel_pkg::chan_word_t [5:0] sync3;
    io_channel_pkg::chan_word_t [5:0] stable;
    io_channel_pkg::chan_word_t       rd_data;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  chan_store_if st();

  io_channel_pkg::chan_word_t pins_raw [6];
  io_channel_pkg::chan_word_t pin_mask [6];

  assign pins_raw[0] = key_code_pins_i;
  assign pins_raw[1] = mark_rate_pins_i;
  assign pins_raw[2] = inertial_stat_pins_i;
  assign pins_raw[3] = hand_ctrl_pins_i;
  assign pins_raw[4] = thruster_fail_pins_i;
  assign pins_raw[5] = radar_stat_pins_i;

  // Unused and spare bit positions read as zero whatever the pins carry
  assign pin_mask[0] = `KEY_CODE_MASK;          // [R17]
  assign pin_mask[1] = `MARK_RATE_MASK;         // [R18]
  assign pin_mask[2] = `INERTIAL_STAT_MASK;     // [R19] [R20]
  assign pin_mask[3] = `HAND_CTRL_MASK;         // [R21]
  assign pin_mask[4] = `THRUSTER_FAIL_MASK;     // [R22]
  assign pin_mask[5] = `RADAR_STAT_MASK;        // [R23]

  ////////////////////////////////////////////////////////////////////////////
  // Output word store

  out_channel_store u_store
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .st         (st)
  );

  // Writes to input channels or unmapped addresses are dropped
  assign st.wr_en   = wr_i && (addr_i <= `COUNTER_CTRL_IDX);  // [R24]
  assign st.wr_sel  = addr_i[1:0];
  assign st.wr_data = wr_data_i;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and read mux

  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < 6; i++)
    begin
      state_next.sync1[i] = pins_raw[i];
      state_next.sync2[i] = state_reg.sync1[i];
      state_next.sync3[i] = state_reg.sync2[i];
      // A bit changes only once stages two and three agree
      for (int b = 0; b < 15; b++)
      begin
        if (state_reg.sync2[i][b] == state_reg.sync3[i][b])
        begin
          state_next.stable[i][b] = state_reg.sync3[i][b];
        end
      end
    end
    state_next.rd_data = 15'h0000;
    if (rd_i)
    begin
      case (addr_i)
        `SUBSYS_CTRL_IDX:   state_next.rd_data = st.out_word[0];  // [R24]
        `RADAR_CTRL_IDX:    state_next.rd_data = st.out_word[1];
        `COUNTER_CTRL_IDX:  state_next.rd_data = st.out_word[2];
        `KEY_CODE_IDX:      state_next.rd_data = state_reg.stable[0] & pin_mask[0];
        `MARK_RATE_IDX:     state_next.rd_data = state_reg.stable[1] & pin_mask[1];
        `INERTIAL_STAT_IDX: state_next.rd_data = state_reg.stable[2] & pin_mask[2];
        `HAND_CTRL_IDX:     state_next.rd_data = state_reg.stable[3] & pin_mask[3];
        `THRUSTER_FAIL_IDX: state_next.rd_data = state_reg.stable[4] & pin_mask[4];
        `RADAR_STAT_IDX:    state_next.rd_data = state_reg.stable[5] & pin_mask[5];
        default:            state_next.rd_data = 15'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_data_o = state_reg.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Discrete outputs, held until the channel is rewritten [R25]

  assign subsystem_misc_o             = {st.out_word[0][6:4], st.out_word[0][1:0]};
  assign display_inertial_en_o        = st.out_word[0][7];    // [R2]
  assign descent_trim_o               = st.out_word[0][11:8]; // [R1]
  assign landing_radar_position_o     = st.out_word[0][12];   // [R3]
  assign rendezvous_radar_autotrack_o = st.out_word[0][13];   // [R4]
  assign turn_on_delay_done_o         = st.out_word[0][14];   // [R5]

  assign radar_data_select_o          = st.out_word[1][3:0];  // [R6]
  assign link_process_ctrl_o          = st.out_word[1][6:4];  // [R7]
  assign hand_ctrl_process_o          = st.out_word[1][8:7];  // [R7]
  assign restart_alarm_inhibit_o      = st.out_word[1][9];    // [R8]
  assign standby_enable_o             = st.out_word[1][10];   // [R9]
  assign interrupt_circuit_reset_o    = st.out_word[1][13:11];// [R10]
  assign jet_timing_counter_en_o      = st.out_word[1][14];   // [R11]

  assign crosslink_enable_o           = st.out_word[2][0];    // [R12]
  assign altitude_indicator_ctrl_o    = st.out_word[2][2:1];  // [R13]
  assign throttle_gating_en_o         = st.out_word[2][3];    // [R14]
  assign counter_spare_o              = st.out_word[2][4];
  assign gyro_torque_ctrl_o           = st.out_word[2][9:5];  // [R15]
  assign rendezvous_radar_drive_o     = st.out_word[2][11:10];// [R16]
  assign inertial_gimbal_drive_o      = st.out_word[2][14:12];// [R16]

endmodule // io_channel_bank

/* verification/input_equipment.sv */
// Behavioural crew panel, switch and radar equipment behind the input pins
`timescale 1ns/10ps
module input_equipment
(
  input  wire logic [14:0] pat_i,
  output logic      [14:0] key_code_o,
  output logic      [14:0] mark_rate_o,
  output logic      [14:0] inertial_stat_o,
  output logic      [14:0] hand_ctrl_o,
  output logic      [14:0] thruster_fail_o,
  output logic      [14:0] radar_stat_o
);
  // Spare and unused bits are driven too, so masking in the bank is exercised
  assign key_code_o      = pat_i;
  assign mark_rate_o     = pat_i ^ 15'h0111;
  assign inertial_stat_o = pat_i ^ 15'h0222;
  assign hand_ctrl_o     = pat_i ^ 15'h0333;
  assign thruster_fail_o = pat_i ^ 15'h0444;
  assign radar_stat_o    = pat_i ^ 15'h0555;
endmodule // input_equipment

/* verification/io_channel_monitor.sv */
// Port checker for the io channel bank
`timescale 1ns/10ps
module io_channel_monitor
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [14:0] wr_data_i,
  input  wire logic [14:0] rd_data_o,
  input  wire logic [3:0]  descent_trim_o,
  input  wire logic        display_inertial_en_o,
  input  wire logic        landing_radar_position_o,
  input  wire logic        rendezvous_radar_autotrack_o,
  input  wire logic        turn_on_delay_done_o,
  input  wire logic [4:0]  subsystem_misc_o,
  input  wire logic [3:0]  radar_data_select_o,
  input  wire logic [2:0]  link_process_ctrl_o,
  input  wire logic [1:0]  hand_ctrl_process_o,
  input  wire logic        restart_alarm_inhibit_o,
  input  wire logic        standby_enable_o,
  input  wire logic [2:0]  interrupt_circuit_reset_o,
  input  wire logic        jet_timing_counter_en_o,
  input  wire logic        crosslink_enable_o,
  input  wire logic [1:0]  altitude_indicator_ctrl_o,
  input  wire logic        throttle_gating_en_o,
  input  wire logic        counter_spare_o,
  input  wire logic [4:0]  gyro_torque_ctrl_o,
  input  wire logic [1:0]  rendezvous_radar_drive_o,
  input  wire logic [2:0]  inertial_gimbal_drive_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [12:0] ch0;
  logic [14:0] ch1;
  logic [14:0] ch2;
  assign ch0 = {turn_on_delay_done_o, rendezvous_radar_autotrack_o, landing_radar_position_o,
    descent_trim_o, display_inertial_en_o, subsystem_misc_o};
  assign ch1 = {jet_timing_counter_en_o, interrupt_circuit_reset_o, standby_enable_o,
    restart_alarm_inhibit_o, hand_ctrl_process_o, link_process_ctrl_o, radar_data_select_o};
  assign ch2 = {inertial_gimbal_drive_o, rendezvous_radar_drive_o, gyro_torque_ctrl_o,
    counter_spare_o, throttle_gating_en_o, altitude_indicator_ctrl_o, crosslink_enable_o};
  sequence wr_at(logic [3:0] a);
    wr_i && addr_i == a;
  endsequence
  AST_TRIM: assert property (wr_at(4'h0) |=> descent_trim_o == $past(wr_data_i[11:8]))
    else $error("trim bits wrong");
  AST_DISP: assert property (wr_at(4'h0) |=> display_inertial_en_o == $past(wr_data_i[7]))
    else $error("display enable wrong");
  AST_CH0_TOP: assert property (wr_at(4'h0) |=>
    ch0[12:10] == $past(wr_data_i[14:12]))
    else $error("radar or delay bit wrong");
  AST_SEL: assert property (wr_at(4'h1) |=> radar_data_select_o == $past(wr_data_i[3:0]))
    else $error("radar select wrong");
  AST_PROC: assert property (wr_at(4'h1) |=> ch1[8:4] == $past(wr_data_i[8:4]))
    else $error("process control wrong");
  AST_INTERNAL: assert property (wr_at(4'h1) |=>
    ch1[14:9] == $past(wr_data_i[14:9]))
    else $error("internal control wrong");
  AST_CH2: assert property (wr_at(4'h2) |=>
    ch2 == $past(wr_data_i))
    else $error("counter control wrong");
  AST_HOLD: assert property (!(wr_i && addr_i < 4'h3) |=> $stable({ch0, ch1, ch2}))
    else $error("output moved without write");
  AST_RD_IDLE: assert property (!rd_i |=> rd_data_o == 15'h0000)
    else $error("read data outside read");
  AST_RD_CH1: assert property (rd_i && addr_i == 4'h1 |=> rd_data_o == $past(ch1))
    else $error("readback differs from outputs");
  AST_RD_GAP: assert property (rd_i && addr_i > 4'h8 |=> rd_data_o == 15'h0000)
    else $error("unmapped read not zero");
endmodule // io_channel_monitor
////////////////////////////////////////////////////////////////
bind io_channel_bank io_channel_monitor io_channel_monitor_inst (.*);

/* verification/tb.sv */
// Self-checking bench for the io channel bank
`timescale 1ns/10ps
`include "io_channel_consts.svh"
module tb;
  logic core_clk_i, rst_i, wr_i, rd_i;
  logic [3:0] addr_i, descent_trim_o, radar_data_select_o;
  logic [14:0] wr_data_i, rd_data_o, pat, key_code_pins_i, mark_rate_pins_i;
  logic [14:0] inertial_stat_pins_i, hand_ctrl_pins_i, thruster_fail_pins_i, radar_stat_pins_i;
  logic [4:0] subsystem_misc_o, gyro_torque_ctrl_o;
  logic [2:0] link_process_ctrl_o, interrupt_circuit_reset_o, inertial_gimbal_drive_o;
  logic [1:0] hand_ctrl_process_o, altitude_indicator_ctrl_o, rendezvous_radar_drive_o;
  logic display_inertial_en_o, landing_radar_position_o, rendezvous_radar_autotrack_o;
  logic turn_on_delay_done_o, restart_alarm_inhibit_o, standby_enable_o;
  logic jet_timing_counter_en_o, crosslink_enable_o, throttle_gating_en_o, counter_spare_o;
  logic [14:0] word [3];
  logic [14:0] msk [6];
  logic [14:0] ex;
  int fails;
  int num_checks;
  io_channel_bank io_channel_bank_inst (.*);
  input_equipment input_equipment_inst (.pat_i(pat), .key_code_o(key_code_pins_i),
    .mark_rate_o(mark_rate_pins_i), .inertial_stat_o(inertial_stat_pins_i),
    .hand_ctrl_o(hand_ctrl_pins_i), .thruster_fail_o(thruster_fail_pins_i),
    .radar_stat_o(radar_stat_pins_i));
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim;
    $display("Checks %0d, failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [14:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    // Read-only and unmapped indices must leave the mirror untouched
    if (a < 4'h3)
      word[a[1:0]] = d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [14:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, e);
  endtask
  task automatic chk_out;
    #1;
    chk({2'b00, turn_on_delay_done_o, rendezvous_radar_autotrack_o, landing_radar_position_o,
      descent_trim_o, display_inertial_en_o, subsystem_misc_o},
      {2'b00, word[0][14:4], word[0][1:0]});
    chk({jet_timing_counter_en_o, interrupt_circuit_reset_o, standby_enable_o,
      restart_alarm_inhibit_o, hand_ctrl_process_o, link_process_ctrl_o, radar_data_select_o},
      word[1]);
    chk({inertial_gimbal_drive_o, rendezvous_radar_drive_o, gyro_torque_ctrl_o, counter_spare_o,
      throttle_gating_en_o, altitude_indicator_ctrl_o, crosslink_enable_o},
      word[2]);
  endtask
  initial
  begin
    #20000;
    fails++;
    end_sim;
  end
  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wr_data_i = 15'h0000;
    pat = 15'h7FFF;
    word = '{default: 15'h0000};
    msk = '{`KEY_CODE_MASK, `MARK_RATE_MASK, `INERTIAL_STAT_MASK, `HAND_CTRL_MASK,
      `THRUSTER_FAIL_MASK, `RADAR_STAT_MASK};
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    chk_out;
    for (int c = 0; c < 3; c++)
      rd(c[3:0], 15'h0000);
    // A walking one exposes swapped or stuck output bits; other channels must hold
    for (int b = 0; b < 16; b++)
      for (int c = 0; c < 3; c++)
      begin
        wr(c[3:0], (b == 15) ? 15'h7FFF : 15'h0001 << b);
        chk_out;
        rd(c[3:0], word[c]);
      end
    wr(4'h3, 15'h0000);
    wr(4'hF, 15'h0000);
    chk_out;
    rd(4'h9, 15'h0000);
    rd(4'hF, 15'h0000);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge core_clk_i);
      pat <= (p == 0) ? 15'h7FFF : 15'h2A5A;
      repeat (6) @(posedge core_clk_i);
      for (int k = 0; k < 6; k++)
      begin
        ex = (pat ^ (15'(k) * 15'h0111)) & msk[k];
        rd(4'(k + 3), ex);
      end
    end
    chk_out;
    end_sim;
  end
endmodule // tb
